/* File: core/bsc_ctrl.sv */
`timescale 1ns/1ps
`default_nettype none
`include "bsc_consts.svh"
module bsc_ctrl import bsc_pkg::*; #(
  parameter bit IS_INTERNAL = 1'h1
) (
  input  wire logic       i_clk,
  input  wire logic       i_reset,
  input  wire logic       i_int_hot_reset,
  input  wire bsc_req_t   i_req,
  input  wire bsc_tlp_t   i_far_tlp,
  input  wire logic [1:0] i_peer_mode,
  input  wire logic       i_peer_force,
  input  wire logic       i_far_reset_active,
  input  wire logic       i_ntb_mode,
  input  wire logic       i_bridge_reset_pin_n,
  output logic [1:0]      o_mode,
  output logic [7:0]      o_rdata,
  output logic            o_rvalid,
  output logic            o_rzero,
  output logic            o_cfg_retry,
  output logic            o_drop,
  output logic            o_credit,
  output logic            o_link_keep,
  output logic            o_force_peer,
  output logic            o_dev_reset
);
  // ****************************************************************
  // State and helpers
  // ****************************************************************
  bsc_state_t st;
  bsc_state_t next_st;
  logic       pin_level;
  logic [1:0] mode_rst;
  logic       in_cap;
  logic       is_ctl;
  logic       locked;
  logic       far_event;
  logic       pin_event;
  logic [7:0] ctl_view;

  assign mode_rst = IS_INTERNAL ? `BSC_MODE_RST_INT : `BSC_MODE_RST_EXT;

  // Pin synchroniser
  bsc_pin_sync u_pin_sync (
    .i_clk   (i_clk),
    .i_reset (i_reset),
    .i_pin   (i_bridge_reset_pin_n),
    .o_level (pin_level)
  );

  // Address decode and event edges
  always_comb begin
    in_cap    = (i_req.addr >= `BSC_CAP_BASE) && (i_req.addr <= `BSC_CAP_LAST);
    is_ctl    = (i_req.addr == `BSC_CTL_ADDR);
    locked    = i_req.from_far && st.prot;
    far_event = i_far_reset_active && !st.far_rst_prev;
    pin_event = !pin_level && st.pin_prev;
    ctl_view  = 8'h00;
    ctl_view[1:0] = st.mode;
    ctl_view[`BSC_BIT_PROT] = st.prot;
    ctl_view[`BSC_BIT_RESET_ACTION_ENABLE] = st.reset_action_enable;
    ctl_view[`BSC_BIT_RA]   = st.ra;
    ctl_view[`BSC_BIT_PIN_RESET_TO_DEVICE_ENABLE] = st.pin_reset_to_device_enable;
  end

  // ****************************************************************
  // Next state
  // ****************************************************************
  always_comb begin
    next_st = st;
    next_st.peer_prev    = i_peer_mode;
    next_st.far_rst_prev = i_far_reset_active;
    next_st.pin_prev     = pin_level;
    next_st.rvalid       = 1'h0;
    next_st.rzero        = 1'h0;
    next_st.cfg_retry    = 1'h0;
    next_st.drop         = 1'h0;
    next_st.credit       = 1'h0;
    next_st.force_peer   = 1'h0;
    next_st.dev_reset    = 1'h0;
    next_st.link_keep    = 1'h1;

    // Software write, ignored when far side is locked
    if (i_req.valid && i_req.write && is_ctl && !locked) begin
      if (i_req.wdata[1:0] != `BSC_MODE_RSVD) begin
        next_st.mode = i_req.wdata[1:0];
      end
      next_st.prot = i_req.wdata[`BSC_BIT_PROT];
      if (IS_INTERNAL) begin
        next_st.reset_action_enable = i_req.wdata[`BSC_BIT_RESET_ACTION_ENABLE];
        next_st.ra   = i_req.wdata[`BSC_BIT_RA];
      end
      next_st.pin_reset_to_device_enable = i_req.wdata[`BSC_BIT_PIN_RESET_TO_DEVICE_ENABLE];
      next_st.dev_reset = i_req.wdata[`BSC_BIT_RST];
    end

    // Reads, zeroed for locked far access
    if (i_req.valid && !i_req.write) begin
      next_st.rvalid = 1'h1;
      next_st.rdata  = is_ctl ? ctl_view : 8'h00;
      if (locked && in_cap && i_req.addr > `BSC_HDR_LAST) begin
        next_st.rzero = 1'h1;
        next_st.rdata = 8'h00;
      end
    end

    if (st.mode != `BSC_MODE_ENABLED &&
        st.peer_prev == `BSC_MODE_ENABLED &&
        i_peer_mode != `BSC_MODE_ENABLED) begin
      next_st.mode = `BSC_MODE_ENABLED;
    end

    if (IS_INTERNAL && st.reset_action_enable && far_event) begin
      if (st.ra) begin
        next_st.mode = `BSC_MODE_NOTRDY;
      end else begin
        next_st.force_peer = 1'h1;
      end
    end
    if (i_peer_force) begin
      next_st.mode = `BSC_MODE_NOTRDY;
    end

    if (pin_event && st.pin_reset_to_device_enable && i_ntb_mode) begin
      next_st.dev_reset = 1'h1;
    end

    if (i_int_hot_reset) begin
      next_st.mode = mode_rst;
    end

    // Far side arrivals
    if (i_far_tlp.valid) begin
      case (st.mode)
        `BSC_MODE_NOTRDY: begin
          next_st.cfg_retry = i_far_tlp.is_cfg;
          next_st.drop      = !i_far_tlp.is_cfg;
        end
        `BSC_MODE_DISABLE: begin
          next_st.drop = 1'h1;
        end
        default: begin
          next_st.drop = 1'h0;
        end
      endcase
      next_st.credit = 1'h1;
    end
  end

  // ****************************************************************
  // Registers
  // ****************************************************************
  // fundamental reset defaults
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      st      <= '0;
      st.mode <= IS_INTERNAL ? `BSC_MODE_RST_INT : `BSC_MODE_RST_EXT;
      st.prot <= `BSC_PERSIST_RST;
      st.reset_action_enable <= `BSC_PERSIST_RST;
      st.ra   <= `BSC_PERSIST_RST;
      st.pin_reset_to_device_enable <= `BSC_PERSIST_RST;
      st.pin_prev <= 1'h1;
    end else begin
      st <= next_st;
    end
  end

  // Outputs from flip-flops
  assign o_mode       = st.mode;
  assign o_rdata      = st.rdata;
  assign o_rvalid     = st.rvalid;
  assign o_rzero      = st.rzero;
  assign o_cfg_retry  = st.cfg_retry;
  assign o_drop       = st.drop;
  assign o_credit     = st.credit;
  assign o_force_peer = st.force_peer;
  assign o_dev_reset  = st.dev_reset;
  assign o_link_keep  = st.link_keep;

  // ****************************************************************
  // Assertions
  // ****************************************************************
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_reset);

  sequence s_far_reset_armed;
    IS_INTERNAL && st.reset_action_enable && !st.ra && i_far_reset_active
      && !st.far_rst_prev;
  endsequence

  a_mode_not_rsvd: assert property (
    o_mode != `BSC_MODE_RSVD) else $error("mode reached reserved code");
  a_retry_notready: assert property (
    i_far_tlp.valid && i_far_tlp.is_cfg && o_mode == `BSC_MODE_NOTRDY
    |=> o_cfg_retry && !o_drop) else $error("no retry in not ready");
  a_drop_disabled: assert property (
    i_far_tlp.valid && o_mode == `BSC_MODE_DISABLE |=> o_drop)
    else $error("arrival not discarded");
  a_credit_drop: assert property (
    o_drop |-> o_credit) else $error("discard without credit");
  a_deadlock_free: assert property (
    o_mode != `BSC_MODE_ENABLED && st.peer_prev == `BSC_MODE_ENABLED
    && i_peer_mode != `BSC_MODE_ENABLED && !i_peer_force
    && !i_int_hot_reset && !(IS_INTERNAL && st.reset_action_enable && far_event)
    |=> o_mode == `BSC_MODE_ENABLED) else $error("deadlock kept");
  a_lock_write: assert property (
    i_req.valid && i_req.write && i_req.from_far && st.prot
    && !i_peer_force && !i_int_hot_reset && !i_far_reset_active
    && i_peer_mode == st.peer_prev
    |=> $stable(st.prot) && $stable(st.pin_reset_to_device_enable) && $stable(o_mode))
    else $error("locked write changed state");
  a_lock_read: assert property (
    i_req.valid && !i_req.write && i_req.from_far && st.prot
    && i_req.addr == `BSC_CTL_ADDR |=> o_rvalid && o_rdata == 8'h00)
    else $error("locked read not zero");
  a_ext_ra_zero: assert property (
    !IS_INTERNAL |-> !st.reset_action_enable && !st.ra) else $error("external action set");
  a_action_once: assert property (
    s_far_reset_armed |=> o_force_peer ##1 !o_force_peer)
    else $error("reset action not single");
  a_rst_reads_zero: assert property (
    o_rvalid |-> !o_rdata[`BSC_BIT_RST]) else $error("reset bit read one");
  a_pin_reset: assert property (
    !pin_level && st.pin_prev && st.pin_reset_to_device_enable && i_ntb_mode |=> o_dev_reset)
    else $error("pin reset not propagated");
endmodule
`default_nettype wire

/* File: core/bsc_consts.svh */
// Functional notes
// - The mode field codes 0x0 as enabled, 0x1 as not ready, 0x2 as disabled; 0x3 is reserved.
// - In not ready mode, far-side configuration requests get a retry completion and all else is ignored.
// - In disabled mode, far-side arrivals are discarded while near-to-far traffic still flows.
// - In not ready and disabled modes the far link and data link layers keep running.
// - Every discarded arrival still returns its flow control credits.
// - When this side is already not ready or disabled and the peer becomes so, this side goes enabled.
// - The mode resets to 0x0 externally and 0x1 internally, restored only by internal resets.
// - With write protection set, far-side writes to the capability complete but change nothing.
// - With write protection set, far-side capability reads return zero except the capability header.
// - With reset action enabled, a far-side reset triggers the selected reset action.
// - Reset action enable and select work only on the internal side and read 0x0 elsewhere.
// - Select 0x0 forces the peer mode to not ready, 0x1 forces this mode to not ready.
// - Bit 5 with non-transparent operation turns a bridge reset pin assertion into a device reset.
// - Writing one to bit 7 starts a device reset; zero does nothing and the bit reads zero.
// - Bits 2 to 5 reset to 0x0 and survive external fundamental and all hot resets.
`ifndef BSC_CONSTS_SVH
`define BSC_CONSTS_SVH
`define BSC_CTL_ADDR     12'h078
`define BSC_CAP_BASE     12'h074
`define BSC_CAP_LAST     12'h0B3
`define BSC_HDR_LAST     12'h077
`define BSC_MODE_ENABLED 2'h0
`define BSC_MODE_NOTRDY  2'h1
`define BSC_MODE_DISABLE 2'h2
`define BSC_MODE_RSVD    2'h3
`define BSC_MODE_RST_EXT 2'h0
`define BSC_MODE_RST_INT 2'h1
`define BSC_PERSIST_RST  1'h0
`define BSC_BIT_PROT     2
`define BSC_BIT_RESET_ACTION_ENABLE     3
`define BSC_BIT_RA       4
`define BSC_BIT_PIN_RESET_TO_DEVICE_ENABLE     5
`define BSC_BIT_RST      7
`endif

/* File: core/bsc_pkg.sv */
package bsc_pkg;
  // Register access request on the configuration / BAR4 path
  typedef struct packed {
    logic        valid;
    logic        write;
    logic        from_far;
    logic [11:0] addr;
    logic [7:0]  wdata;
  } bsc_req_t;

  // Transaction arriving on the far side
  typedef struct packed {
    logic valid;
    logic is_cfg;
  } bsc_tlp_t;

  // Complete state of the control block
  typedef struct packed {
    logic [1:0] mode;
    logic       prot;
    logic       reset_action_enable;
    logic       ra;
    logic       pin_reset_to_device_enable;
    logic [1:0] peer_prev;
    logic       far_rst_prev;
    logic       pin_prev;
    logic [7:0] rdata;
    logic       rvalid;
    logic       rzero;
    logic       cfg_retry;
    logic       drop;
    logic       credit;
    logic       force_peer;
    logic       dev_reset;
    logic       link_keep;
  } bsc_state_t;

  // Three-stage pin synchroniser state
  typedef struct packed {
    logic [2:0] stage;
    logic       level;
  } bsc_sync_t;
endpackage

/* File: core/bsc_pin_sync.sv */
`timescale 1ns/1ps
`default_nettype none
// Three-stage synchroniser; level changes once stages two and three agree
module bsc_pin_sync import bsc_pkg::*; (
  input  wire logic i_clk,
  input  wire logic i_reset,
  input  wire logic i_pin,
  output logic      o_level
);
  bsc_sync_t st;
  bsc_sync_t next_st;

  // Shift chain; level follows once stages two and three agree
  always_comb begin
    next_st       = st;
    next_st.stage = {st.stage[1:0], i_pin};
    if (st.stage[1] == st.stage[2]) begin
      next_st.level = st.stage[2];
    end
  end

  // State register, idle high so reset gives no false edge
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      st <= '1;
    end else begin
      st <= next_st;
    end
  end

  // Filtered level straight from its flip-flop
  assign o_level = st.level;
endmodule
`default_nettype wire

/* File: tb/bsc_peer_model.sv */
`timescale 1ns/1ps
`default_nettype none
// Peer side of the bridge, holding its own mode field
module bsc_peer_model (
  input  wire logic       i_clk,
  input  wire logic       i_reset,
  input  wire logic       i_force,
  input  wire logic       i_set,
  input  wire logic [1:0] i_set_mode,
  output logic [1:0]      o_mode
);
  // Forced not ready wins over a software write
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) o_mode <= 2'h0;
    else if (i_force) o_mode <= 2'h1;
    else if (i_set) o_mode <= i_set_mode;
  end
endmodule
`default_nettype wire

/* File: tb/bsc_ctrl_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module bsc_ctrl_tb;
  import bsc_pkg::*;
  logic       i_clk = 0, i_reset = 1, hot = 0, far_rst = 0, ntb = 0;
  logic       pin_n = 1, pset = 0, pforce = 0;
  logic [1:0] pm_set = 0, peer_mode, mode;
  bsc_req_t   req = '0;
  bsc_tlp_t   tlp = '0;
  logic [7:0] rdata, ext_rdata;
  logic       rvalid, rzero, retry, drop, credit, keep, fpeer, dres;
  int         n_errors = 0, tests_run = 0;

  // ****************************************
  // Clock, instances
  // ****************************************
  always #10 i_clk = ~i_clk;
  bsc_ctrl #(.IS_INTERNAL(1'b1)) i_bsc_ctrl (.i_clk, .i_reset,
    .i_int_hot_reset(hot), .i_req(req), .i_far_tlp(tlp),
    .i_peer_mode(peer_mode), .i_peer_force(pforce),
    .i_far_reset_active(far_rst), .i_ntb_mode(ntb),
    .i_bridge_reset_pin_n(pin_n), .o_mode(mode), .o_rdata(rdata),
    .o_rvalid(rvalid), .o_rzero(rzero), .o_cfg_retry(retry),
    .o_drop(drop), .o_credit(credit), .o_link_keep(keep),
    .o_force_peer(fpeer), .o_dev_reset(dres));
  bsc_ctrl #(.IS_INTERNAL(1'b0)) i_bsc_ctrl_ext (.i_clk, .i_reset,
    .i_int_hot_reset(hot), .i_req(req), .i_far_tlp(tlp),
    .i_peer_mode(mode), .i_peer_force(fpeer),
    .i_far_reset_active(far_rst), .i_ntb_mode(ntb),
    .i_bridge_reset_pin_n(pin_n), .o_mode(), .o_rdata(ext_rdata),
    .o_rvalid(), .o_rzero(), .o_cfg_retry(), .o_drop(), .o_credit(),
    .o_link_keep(), .o_force_peer(), .o_dev_reset());
  bsc_peer_model i_bsc_peer_model (.i_clk, .i_reset, .i_force(fpeer),
    .i_set(pset), .i_set_mode(pm_set), .o_mode(peer_mode));

  // ****************************************
  // Shared tasks
  // ****************************************
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // One register access, answer sampled once it has settled
  task automatic acc(input logic w, f, input logic [11:0] a,
                     input logic [7:0] d);
    @(posedge i_clk);
    req <= '{1'b1, w, f, a, d};
    @(posedge i_clk);
    req.valid <= 1'b0;
    #1;
  endtask
  task automatic arr(input logic c);
    @(posedge i_clk);
    tlp <= '{1'b1, c};
    @(posedge i_clk);
    tlp.valid <= 1'b0;
    #1;
  endtask
  task automatic far_event();
    @(posedge i_clk);
    far_rst <= ~far_rst;
    repeat (3) @(posedge i_clk);
    #1;
  endtask

  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_reset();
    acc(0, 0, 12'h078, 8'h00);
    chk({7'h00, rvalid}, 8'h01);
    chk(rdata, 8'h01);
    chk(ext_rdata, 8'h00);
    chk({7'h00, keep}, 8'h01);
  endtask
  task automatic t_arrivals();
    arr(1);
    chk({5'h00, retry, drop, credit}, 8'h05);
    arr(0);
    chk({5'h00, retry, drop, credit}, 8'h03);
    acc(1, 0, 12'h078, 8'h02);
    arr(1);
    chk({5'h00, retry, drop, credit}, 8'h03);
    acc(1, 0, 12'h078, 8'h00);
    arr(0);
    chk({5'h00, retry, drop, credit}, 8'h01);
  endtask
  task automatic t_mode();
    acc(1, 0, 12'h078, 8'h03);
    chk({6'h00, mode}, 8'h00);
    acc(1, 0, 12'h078, 8'h81);
    chk({7'h00, dres}, 8'h01);
    acc(0, 0, 12'h078, 8'h00);
    chk(rdata, 8'h01);
  endtask
  task automatic t_prot();
    acc(1, 0, 12'h078, 8'h04);
    acc(1, 1, 12'h078, 8'h00);
    acc(0, 0, 12'h078, 8'h00);
    chk(rdata, 8'h04);
    acc(0, 1, 12'h078, 8'h00);
    chk({7'h00, rzero}, 8'h01);
    acc(0, 1, 12'h074, 8'h00);
    chk({7'h00, rzero}, 8'h00);
  endtask
  task automatic t_action();
    acc(1, 0, 12'h078, 8'h18);
    acc(0, 0, 12'h078, 8'h00);
    chk(ext_rdata, 8'h00);
    far_event();
    chk({6'h00, mode}, 8'h01);
    acc(1, 0, 12'h078, 8'h08);
    chk({6'h00, mode}, 8'h00);
    far_event();
    far_event();
    chk({6'h00, peer_mode}, 8'h01);
    chk({6'h00, mode}, 8'h00);
  endtask
  task automatic t_deadlock();
    @(posedge i_clk);
    pset <= 1'b1;
    @(posedge i_clk);
    pset <= 1'b0;
    acc(1, 0, 12'h078, 8'h01);
    @(posedge i_clk);
    pset <= 1'b1;
    pm_set <= 2'h2;
    @(posedge i_clk);
    pset <= 1'b0;
    repeat (2) @(posedge i_clk);
    #1;
    chk({6'h00, mode}, 8'h00);
    @(posedge i_clk);
    pforce <= 1'h1;
    @(posedge i_clk);
    pforce <= 1'h0;
    #1;
    chk({6'h00, mode}, 8'h01);
  endtask
  task automatic t_pin_hot();
    acc(1, 0, 12'h078, 8'h20);
    @(posedge i_clk);
    ntb <= 1'b1;
    pin_n <= 1'b0;
    for (int k = 0; k < 10 && dres !== 1'b1; k++) begin
      @(posedge i_clk);
      #1;
    end
    chk({7'h00, dres}, 8'h01);
    @(posedge i_clk);
    hot <= 1'b1;
    @(posedge i_clk);
    hot <= 1'b0;
    acc(0, 0, 12'h078, 8'h00);
    chk(rdata, 8'h21);
  endtask

  task automatic end_sim();
    $display("errors %0d checks %0d", n_errors, tests_run);
    if (n_errors == 0 && tests_run > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  // Main sequence after 16 reset cycles
  initial begin
    repeat (16) @(posedge i_clk);
    i_reset <= 1'b0;
    t_reset();
    t_arrivals();
    t_mode();
    t_prot();
    t_action();
    t_deadlock();
    t_pin_hot();
    end_sim();
  end
  // Watchdog
  initial begin
    #100000;
    n_errors++;
    end_sim();
  end
endmodule
`default_nettype wire
